// ### verilog/fspsc_pkg.sv
// fspsc_pkg: shared constants for the self-programming section controller
package fspsc_pkg;

  // ----------------------------------------------------------------
  // flash geometry (word addresses)
  // ----------------------------------------------------------------
  localparam int          FLASH_AW     = 16;
  localparam logic [15:0] HALT_START   = 16'hF000;
  localparam logic [15:0] BOOT_WORDS_0 = 16'h1000;
  localparam logic [15:0] BOOT_WORDS_1 = 16'h0800;
  localparam logic [15:0] BOOT_WORDS_2 = 16'h0400;
  localparam logic [15:0] BOOT_WORDS_3 = 16'h0200;

  // ----------------------------------------------------------------
  // register map and field positions
  // ----------------------------------------------------------------
  localparam int         REG_AW        = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_LOCK      = 8'h04;
  localparam logic [7:0] REG_FUSE      = 8'h08;
  localparam logic [7:0] REG_STAT      = 8'h0C;
  localparam int         CTRL_EN_BIT   = 0;
  localparam int         CTRL_ERS_BIT  = 1;
  localparam int         CTRL_WR_BIT   = 2;
  localparam int         CTRL_LCK_BIT  = 3;
  localparam int         CTRL_CLR_BIT  = 4;
  localparam int         CTRL_BUSY_BIT = 6;
  localparam int         LOCK_APP_LO   = 0;
  localparam int         LOCK_APP_HI   = 1;
  localparam int         LOCK_BOOT_LO  = 2;
  localparam int         LOCK_BOOT_HI  = 3;
  localparam int         STAT_RUN_BIT  = 0;
  localparam int         STAT_STL_BIT  = 1;
  localparam int         STAT_REF_BIT  = 2;
  localparam logic [3:0] LOCK_RESET    = 4'hF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned OP_TIME_NS    = 4000000;
  localparam int unsigned OP_CYCLES     = OP_TIME_NS / CLK_PERIOD_NS;

endpackage

// ### verilog/fspsc_if.sv
// fspsc_if: carriers between the controller and its helper modules
`timescale 1ns/100ps
`default_nettype none

interface fspsc_region_if;
  logic [15:0] addr;
  logic [1:0]  fuses;
  logic        in_boot;
  logic        in_halt;
  modport dec  (input addr, input fuses, output in_boot, output in_halt);
  modport user (output addr, output fuses, input in_boot, input in_halt);
endinterface

interface fspsc_timer_if;
  logic start;
  logic busy;
  logic done;
  modport tmr  (input start, output busy, output done);
  modport user (output start, input busy, input done);
endinterface

`default_nettype wire

// ### verilog/fspsc_region.sv
// fspsc_region: classifies a flash word address into its sections
`timescale 1ns/100ps
`default_nettype none

module fspsc_region
  import fspsc_pkg::*;
(
  fspsc_region_if.dec rif
);

  logic [15:0] boot_words;
  logic [15:0] boot_start;

  always_comb begin
    case (rif.fuses)
      2'b00:   boot_words = BOOT_WORDS_0;
      2'b01:   boot_words = BOOT_WORDS_1;
      2'b10:   boot_words = BOOT_WORDS_2;
      default: boot_words = BOOT_WORDS_3;
    endcase
    boot_start = 16'h0000 - boot_words;
    // boot loader can never reach below the halting region
    if (boot_start < HALT_START) begin
      boot_start = HALT_START;
    end
    rif.in_boot = (rif.addr >= boot_start);
    rif.in_halt = (rif.addr >= HALT_START);
  end

endmodule

`default_nettype wire

// ### verilog/fspsc_timer.sv
// fspsc_timer: times one page erase or page write
`timescale 1ns/100ps
`default_nettype none

module fspsc_timer
  import fspsc_pkg::*;
#(
  parameter int unsigned CYCLES = OP_CYCLES
)(
  input  wire logic        core_clk,
  input  wire logic        srst,
  fspsc_timer_if.tmr       tif
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [31:0] cnt;
  } fspsc_tmr_s;

  fspsc_tmr_s st_reg;
  fspsc_tmr_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (st_reg.busy) begin
      if (st_reg.cnt <= 32'h00000001) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.cnt  = 32'h00000000;
      end else begin
        st_next.cnt = st_reg.cnt - 32'h00000001;
      end
    end else if (tif.start) begin
      st_next.busy = 1'b1;
      st_next.cnt  = 32'(CYCLES);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tif.busy = st_reg.busy;
  assign tif.done = st_reg.done;

endmodule

`default_nettype wire

// ### verilog/fspsc_top.sv
// fspsc_top: self-programming section access controller
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module fspsc_top
  import fspsc_pkg::*;
#(
  parameter int unsigned OP_CYC = OP_CYCLES,
  parameter int          AW     = FLASH_AW
)(
  input  wire logic              core_clk,
  input  wire logic              srst,
  // register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [7:0]        reg_rdata,
  // fuse pins
  input  wire logic [1:0]        boot_size_fuses,
  // store program request from the core
  input  wire logic              store_program_op,
  input  wire logic [AW-1:0]     store_program_pc,
  input  wire logic [AW-1:0]     store_program_ptr,
  input  wire logic [3:0]        store_program_data,
  // program memory load request from the core
  input  wire logic              load_req,
  input  wire logic [AW-1:0]     load_pc,
  input  wire logic [AW-1:0]     load_addr,
  output var  logic              load_valid,
  output var  logic              load_grant,
  // programming interface and chip erase
  input  wire logic              prog_lock_wr,
  input  wire logic [3:0]        prog_lock_data,
  input  wire logic              chip_erase,
  // flash array and core control
  output var  logic              flash_op_start,
  output var  logic              flash_op_erase,
  output var  logic [AW-1:0]     flash_op_addr,
  output var  logic              cpu_stall,
  output var  logic              concurrent_region_busy_flag,
  output var  logic              op_refused
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSPSC_IDLE,
    FSPSC_RUN_CONC,
    FSPSC_RUN_HALT
  } fspsc_state_e;

  typedef struct packed {
    fspsc_state_e    st;
    logic            en;
    logic            ers;
    logic            wr;
    logic            lck;
    logic            busy_flag;
    logic            stall;
    logic            refused;
    logic            ref_sticky;
    logic [3:0]      locks;
    logic            start;
    logic            op_erase;
    logic [AW-1:0]   op_addr;
    logic            ld_valid;
    logic            ld_grant;
    logic [7:0]      rdata;
    logic [1:0]      fuse_s1;
    logic [1:0]      fuse_s2;
  } fspsc_top_s;

  fspsc_top_s s_reg;
  fspsc_top_s s_next;

  // ----------------------------------------------------------------
  // section decoders: op origin, op target, load origin, load target
  // ----------------------------------------------------------------
  localparam int NDEC = 4;

  logic [NDEC-1:0][AW-1:0] dec_addr;
  logic [NDEC-1:0]         dec_boot;
  logic [NDEC-1:0]         dec_halt;

  assign dec_addr[0] = store_program_pc;
  assign dec_addr[1] = store_program_ptr;
  assign dec_addr[2] = load_pc;
  assign dec_addr[3] = load_addr;

  genvar gi;
  generate
    for (gi = 0; gi < NDEC; gi++) begin : g_dec
      fspsc_region_if rif ();
      assign rif.addr     = 16'(dec_addr[gi]);
      assign rif.fuses    = s_reg.fuse_s2;
      assign dec_boot[gi] = rif.in_boot;
      assign dec_halt[gi] = rif.in_halt;
      fspsc_region u_region (
        .rif (rif)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // operation timer
  // ----------------------------------------------------------------
  fspsc_timer_if tif ();

  assign tif.start = s_reg.start;

  fspsc_timer #(
    .CYCLES (OP_CYC)
  ) u_timer (
    .core_clk (core_clk),
    .srst     (srst),
    .tif      (tif)
  );

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic from_boot;
  logic tgt_boot;
  logic tgt_halt;
  logic wr_blocked;
  logic page_op;
  logic ctrl_wr;
  logic lock_wr;
  logic stat_wr;
  logic ld_deny;

  always_comb begin
    from_boot = dec_boot[0];
    tgt_boot  = dec_boot[1];
    tgt_halt  = dec_halt[1];
    // low bit of each pair programmed blocks store writes into its section
    if (tgt_boot) begin
      wr_blocked = ~s_reg.locks[LOCK_BOOT_LO];
    end else begin
      wr_blocked = ~s_reg.locks[LOCK_APP_LO];
    end
    page_op = s_reg.ers | s_reg.wr;
    ctrl_wr = reg_wr && (reg_addr == REG_CTRL);
    lock_wr = reg_wr && (reg_addr == REG_LOCK);
    stat_wr = reg_wr && (reg_addr == REG_STAT);
    // high bit of each pair programmed blocks cross-section loads
    ld_deny = 1'b0;
    if (s_reg.busy_flag && !dec_halt[3]) begin
      ld_deny = 1'b1;
    end
    if (dec_boot[2] && !dec_boot[3] && !s_reg.locks[LOCK_APP_HI]) begin
      ld_deny = 1'b1;
    end
    if (!dec_boot[2] && dec_boot[3] && !s_reg.locks[LOCK_BOOT_HI]) begin
      ld_deny = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.start    = 1'b0;
    s_next.refused  = 1'b0;
    s_next.ld_valid = load_req;
    s_next.ld_grant = load_req && !ld_deny;
    s_next.rdata    = 8'h00;
    // fuses are pins; two flops before anything looks at them
    s_next.fuse_s1  = boot_size_fuses;
    s_next.fuse_s2  = s_reg.fuse_s1;

    // control writes are ignored while a page operation runs
    if (ctrl_wr && s_reg.st == FSPSC_IDLE) begin
      s_next.en  = reg_wdata[CTRL_EN_BIT];
      s_next.ers = reg_wdata[CTRL_ERS_BIT];
      s_next.wr  = reg_wdata[CTRL_WR_BIT];
      s_next.lck = reg_wdata[CTRL_LCK_BIT];
      // flag itself is read-only; only the clear command touches it
      if (reg_wdata[CTRL_CLR_BIT] && reg_wdata[CTRL_EN_BIT]) begin
        s_next.busy_flag = 1'b0;
        s_next.en        = 1'b0;
      end
    end

    if (stat_wr) begin
      s_next.ref_sticky = 1'b0;
    end

    // lock bits only ever move from one to zero here
    if (lock_wr) begin
      s_next.locks = s_next.locks & reg_wdata[3:0];
    end
    if (prog_lock_wr) begin
      s_next.locks = s_next.locks & prog_lock_data;
    end

    case (s_reg.st)
      FSPSC_IDLE: begin
        if (store_program_op && s_reg.en) begin
          if (!from_boot) begin
            s_next.refused    = 1'b1;
            s_next.ref_sticky = 1'b1;
          end else if (s_reg.lck) begin
            s_next.locks = s_next.locks & store_program_data;
            s_next.en    = 1'b0;
            s_next.lck   = 1'b0;
          end else if (page_op && !wr_blocked) begin
            // any page in the whole flash, boot section included
            s_next.start     = 1'b1;
            s_next.op_erase  = s_reg.ers;
            s_next.op_addr   = store_program_ptr;
            s_next.busy_flag = 1'b1;
            if (tgt_halt) begin
              s_next.st    = FSPSC_RUN_HALT;
              s_next.stall = 1'b1;
            end else begin
              s_next.st    = FSPSC_RUN_CONC;
              s_next.stall = 1'b0;
            end
          end else begin
            s_next.refused    = 1'b1;
            s_next.ref_sticky = 1'b1;
          end
        end else if (store_program_op) begin
          s_next.refused    = 1'b1;
          s_next.ref_sticky = 1'b1;
        end
      end
      FSPSC_RUN_CONC: begin
        // a second request cannot start while the array is busy
        if (store_program_op) begin
          s_next.refused    = 1'b1;
          s_next.ref_sticky = 1'b1;
        end
        if (tif.done) begin
          s_next.st  = FSPSC_IDLE;
          s_next.en  = 1'b0;
          s_next.ers = 1'b0;
          s_next.wr  = 1'b0;
        end
      end
      FSPSC_RUN_HALT: begin
        if (tif.done) begin
          s_next.st    = FSPSC_IDLE;
          s_next.stall = 1'b0;
          s_next.en    = 1'b0;
          s_next.ers   = 1'b0;
          s_next.wr    = 1'b0;
        end
      end
      default: begin
        s_next.st    = FSPSC_IDLE;
        s_next.stall = 1'b0;
      end
    endcase

    // chip erase returns every lock bit to unprogrammed, over any set
    if (chip_erase) begin
      s_next.locks = LOCK_RESET;
    end

    // ----------------------------------------------------------------
    // read data, valid only in the cycle after the strobe
    // ----------------------------------------------------------------
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: begin
          s_next.rdata[CTRL_EN_BIT]   = s_reg.en;
          s_next.rdata[CTRL_ERS_BIT]  = s_reg.ers;
          s_next.rdata[CTRL_WR_BIT]   = s_reg.wr;
          s_next.rdata[CTRL_LCK_BIT]  = s_reg.lck;
          s_next.rdata[CTRL_BUSY_BIT] = s_reg.busy_flag;
        end
        REG_LOCK: begin
          s_next.rdata[3:0] = s_reg.locks;
        end
        REG_FUSE: begin
          s_next.rdata[1:0] = s_reg.fuse_s2;
        end
        REG_STAT: begin
          s_next.rdata[STAT_RUN_BIT] = (s_reg.st != FSPSC_IDLE);
          s_next.rdata[STAT_STL_BIT] = s_reg.stall;
          s_next.rdata[STAT_REF_BIT] = s_reg.ref_sticky;
        end
        default: begin
          s_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_reg       <= '0;
      s_reg.st    <= FSPSC_IDLE;
      s_reg.locks <= LOCK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign reg_rdata                   = s_reg.rdata;
  assign load_valid                  = s_reg.ld_valid;
  assign load_grant                  = s_reg.ld_grant;
  assign flash_op_start              = s_reg.start;
  assign flash_op_erase              = s_reg.op_erase;
  assign flash_op_addr               = s_reg.op_addr;
  assign cpu_stall                   = s_reg.stall;
  assign concurrent_region_busy_flag = s_reg.busy_flag;
  assign op_refused                  = s_reg.refused;

endmodule

`default_nettype wire

// ### dv/fspsc_top_asserts.sv
// fspsc_top_asserts: port-level checker for the self-programming controller
`timescale 1ns/100ps
`default_nettype none

module fspsc_top_asserts
  import fspsc_pkg::*;
#(
  parameter int unsigned OP_CYC = OP_CYCLES,
  parameter int          AW     = FLASH_AW
)(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_rdata,
  input  wire logic              store_program_op,
  input  wire logic [AW-1:0]     store_program_pc,
  input  wire logic [AW-1:0]     store_program_ptr,
  input  wire logic              load_req,
  input  wire logic [AW-1:0]     load_addr,
  input  wire logic              load_valid,
  input  wire logic              load_grant,
  input  wire logic              flash_op_start,
  input  wire logic [AW-1:0]     flash_op_addr,
  input  wire logic              cpu_stall,
  input  wire logic              concurrent_region_busy_flag,
  input  wire logic              op_refused
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // stall length counter
  // ----------------------------------------------------------------
  // a counter keeps the long stall window out of unrolled repetitions
  int unsigned stall_cnt_reg;
  always_ff @(posedge core_clk) begin
    if (srst || !cpu_stall) stall_cnt_reg <= 0;
    else stall_cnt_reg <= stall_cnt_reg + 1;
  end

  sequence s_halt_start;
    flash_op_start && cpu_stall;
  endsequence

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_app_origin_ignored: assert property (store_program_op
    && store_program_pc < HALT_START |=> op_refused && !flash_op_start)
    else $error("store op from app section started");
  a_target_from_ptr: assert property (flash_op_start
    |-> flash_op_addr == $past(store_program_ptr)) else $error("op address not the pointer");
  a_conc_keeps_run: assert property (flash_op_start && flash_op_addr < HALT_START
    |-> !cpu_stall) else $error("concurrent region op stalled cpu");
  a_halt_stalls: assert property (flash_op_start && flash_op_addr >= HALT_START
    |-> cpu_stall) else $error("halting region op did not stall");
  a_stall_holds: assert property (s_halt_start |=> cpu_stall [*8])
    else $error("stall dropped early");
  a_stall_full_op: assert property ($fell(cpu_stall) |-> stall_cnt_reg >= OP_CYC)
    else $error("stall shorter than op time");
  a_stall_released: assert property (cpu_stall |-> stall_cnt_reg <= OP_CYC + 3)
    else $error("stall not released after op");
  a_conc_unreadable: assert property (load_req && load_addr < HALT_START
    && concurrent_region_busy_flag |=> load_valid && !load_grant)
    else $error("blocked region load granted");
  a_busy_on_op: assert property (flash_op_start |-> concurrent_region_busy_flag)
    else $error("busy flag low during op");
  a_busy_sw_clear: assert property ($fell(concurrent_region_busy_flag)
    |-> $past(reg_wr) && $past(reg_addr) == REG_CTRL && $past(reg_wdata[CTRL_CLR_BIT]))
    else $error("busy flag fell without clear write");
  a_busy_readback: assert property (reg_rd && reg_addr == REG_CTRL
    |=> reg_rdata[CTRL_BUSY_BIT] == $past(concurrent_region_busy_flag))
    else $error("busy bit readback wrong");
endmodule

bind fspsc_top fspsc_top_asserts #(.OP_CYC(OP_CYC), .AW(AW)) fspsc_top_asserts_i (
  .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .store_program_op(store_program_op), .store_program_pc(store_program_pc),
  .store_program_ptr(store_program_ptr), .load_req(load_req), .load_addr(load_addr),
  .load_valid(load_valid), .load_grant(load_grant), .flash_op_start(flash_op_start),
  .flash_op_addr(flash_op_addr), .cpu_stall(cpu_stall),
  .concurrent_region_busy_flag(concurrent_region_busy_flag), .op_refused(op_refused));

`default_nettype wire

// ### dv/fspsc_core_model.sv
// fspsc_core_model: behavioural cpu core issuing store ops and loads
`timescale 1ns/100ps
`default_nettype none

module fspsc_core_model (
  input  wire logic        core_clk,
  input  wire logic        cpu_stall,
  input  wire logic        load_valid,
  input  wire logic        load_grant,
  input  wire logic        op_refused,
  input  wire logic        flash_op_start,
  output var  logic        store_program_op,
  output var  logic [15:0] store_program_pc,
  output var  logic [15:0] store_program_ptr,
  output var  logic [3:0]  store_program_data,
  output var  logic        load_req,
  output var  logic [15:0] load_pc,
  output var  logic [15:0] load_addr
);
  initial begin
    store_program_op = 1'b0;
    store_program_pc = 16'h0000;
    store_program_ptr = 16'h0000;
    store_program_data = 4'hF;
    load_req = 1'b0;
    load_pc = 16'h0000;
    load_addr = 16'h0000;
  end

  // released lines show the inverse so a stale value never looks valid
  task automatic store(input logic [15:0] pc, input logic [15:0] ptr,
                       input logic [3:0] dat, output logic refd, output logic strt);
    @(posedge core_clk);
    store_program_op <= 1'b1;
    store_program_pc <= pc;
    store_program_ptr <= ptr;
    store_program_data <= dat;
    @(posedge core_clk);
    store_program_op <= 1'b0;
    store_program_pc <= ~pc;
    store_program_ptr <= ~ptr;
    store_program_data <= ~dat;
    #1;
    refd = op_refused;
    strt = flash_op_start;
  endtask

  // a halted core fetches nothing until the stall lifts
  task automatic load(input logic [15:0] pc, input logic [15:0] addr,
                      output logic vld, output logic gnt);
    while (cpu_stall) @(posedge core_clk);
    @(posedge core_clk);
    load_req <= 1'b1;
    load_pc <= pc;
    load_addr <= addr;
    @(posedge core_clk);
    load_req <= 1'b0;
    load_pc <= ~pc;
    load_addr <= ~addr;
    #1;
    vld = load_valid;
    gnt = load_grant;
  endtask
endmodule

`default_nettype wire

// ### dv/fspsc_top_tb.sv
// fspsc_top_tb: directed testbench for the self-programming controller
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module fspsc_top_tb
  import fspsc_pkg::*;
;
  localparam int OPC = 20;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] boot_size_fuses = 2'h0;
  logic prog_lock_wr = 1'b0;
  logic [3:0] prog_lock_data = 4'hF;
  logic chip_erase = 1'b0;
  logic [7:0] reg_rdata;
  logic sp_op, l_req, l_vld, l_gnt, f_start, f_erase, cpu_stall, busy, refused;
  logic [15:0] sp_pc, sp_ptr, l_pc, l_addr, f_addr, bs;
  logic [3:0] sp_data;
  logic [7:0] rd;
  logic refd, strt, lv, lg;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;

  fspsc_top #(.OP_CYC(OPC)) fspsc_top_i (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_size_fuses(boot_size_fuses), .store_program_op(sp_op), .store_program_pc(sp_pc),
    .store_program_ptr(sp_ptr), .store_program_data(sp_data), .load_req(l_req),
    .load_pc(l_pc), .load_addr(l_addr), .load_valid(l_vld), .load_grant(l_gnt),
    .prog_lock_wr(prog_lock_wr), .prog_lock_data(prog_lock_data), .chip_erase(chip_erase),
    .flash_op_start(f_start), .flash_op_erase(f_erase), .flash_op_addr(f_addr),
    .cpu_stall(cpu_stall), .concurrent_region_busy_flag(busy), .op_refused(refused));

  fspsc_core_model fspsc_core_model_i (
    .core_clk(core_clk), .cpu_stall(cpu_stall), .load_valid(l_vld), .load_grant(l_gnt),
    .op_refused(refused), .flash_op_start(f_start), .store_program_op(sp_op),
    .store_program_pc(sp_pc), .store_program_ptr(sp_ptr), .store_program_data(sp_data),
    .load_req(l_req), .load_pc(l_pc), .load_addr(l_addr));

  always #10 core_clk = ~core_clk;

  // whole run is well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // register port and op helpers
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic do_op(input logic [15:0] pc, input logic [15:0] ptr, input logic [7:0] ctl);
    reg_write(REG_CTRL, ctl);
    fspsc_core_model_i.store(pc, ptr, 4'hF, refd, strt);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    reg_read(REG_CTRL, rd);
    `CHK("ctrl reset", 8'h00, rd)
    reg_read(REG_LOCK, rd);
    `CHK("lock reset", 8'h0F, rd)
    reg_write(8'h10, 8'hFF);
    reg_read(8'h10, rd);
    `CHK("unmapped", 8'h00, rd)
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      boot_size_fuses <= i[1:0];
      repeat (3) @(posedge core_clk);
      reg_read(REG_FUSE, rd);
      `CHK("fuse view", {6'h00, i[1:0]}, rd)
      bs = 16'h0000 - (i == 0 ? BOOT_WORDS_0 : i == 1 ? BOOT_WORDS_1 :
                       i == 2 ? BOOT_WORDS_2 : BOOT_WORDS_3);
      do_op(bs - 16'h0001, 16'hF000, 8'h05);
      `CHK("app refused", 1'b1, refd)
      `CHK("app no start", 1'b0, strt)
      do_op(bs, bs, i[0] ? 8'h03 : 8'h05);
      `CHK("boot start", 1'b1, strt)
      `CHK("boot stall", 1'b1, cpu_stall)
      `CHK("op addr", bs, f_addr)
      `CHK("op erase", i[0], f_erase)
      reg_read(REG_STAT, rd);
      `CHK("stat halt", 8'h07, rd)
      repeat (OPC + 4) @(posedge core_clk);
      #1;
      `CHK("stall free", 1'b0, cpu_stall)
      fspsc_core_model_i.load(16'hF000, 16'h0100, lv, lg);
      `CHK("blocked load", 1'b0, lg)
      reg_write(REG_CTRL, 8'h11);
    end
    boot_size_fuses <= 2'h0;
    repeat (3) @(posedge core_clk);
    do_op(16'hF000, 16'h0100, 8'h05);
    `CHK("conc start", 1'b1, strt)
    `CHK("conc run", 1'b0, cpu_stall)
    fspsc_core_model_i.load(16'hF000, 16'hF100, lv, lg);
    `CHK("halt read", 2'b11, {lv, lg})
    fspsc_core_model_i.load(16'hF000, 16'h0100, lv, lg);
    `CHK("conc read", 2'b10, {lv, lg})
    reg_read(REG_CTRL, rd);
    `CHK("busy op", 1'b1, rd[6])
    reg_write(REG_STAT, 8'h00);
    fspsc_core_model_i.store(16'hF000, 16'h0200, 4'hF, refd, strt);
    `CHK("conc again", 2'b10, {refd, strt})
    reg_read(REG_STAT, rd);
    `CHK("stat conc", 8'h05, rd)
    repeat (OPC + 4) @(posedge core_clk);
    reg_read(REG_CTRL, rd);
    `CHK("busy held", 1'b1, rd[6])
    reg_write(REG_CTRL, 8'h11);
    reg_write(REG_CTRL, 8'h40);
    reg_read(REG_CTRL, rd);
    `CHK("busy ro", 1'b0, rd[6])
    fspsc_core_model_i.load(16'h0000, 16'h0100, lv, lg);
    `CHK("conc free", 1'b1, lg)
    reg_write(REG_LOCK, 8'h0E);
    do_op(16'hF000, 16'h0100, 8'h05);
    `CHK("app wlock", 1'b1, refd)
    do_op(16'hF000, 16'hF100, 8'h05);
    `CHK("boot open", 1'b1, strt)
    repeat (OPC + 4) @(posedge core_clk);
    reg_write(REG_CTRL, 8'h11);
    reg_write(REG_CTRL, 8'h09);
    fspsc_core_model_i.store(16'hF000, 16'h0000, 4'hB, refd, strt);
    reg_read(REG_LOCK, rd);
    `CHK("lock set", 8'h0A, rd)
    do_op(16'hF000, 16'hF100, 8'h05);
    `CHK("boot wlock", 1'b1, refd)
    reg_write(REG_LOCK, 8'h0F);
    reg_read(REG_LOCK, rd);
    `CHK("no clear", 8'h0A, rd)
    @(posedge core_clk);
    prog_lock_wr <= 1'b1;
    prog_lock_data <= 4'h5;
    @(posedge core_clk);
    prog_lock_wr <= 1'b0;
    fspsc_core_model_i.load(16'hF000, 16'h0100, lv, lg);
    `CHK("app rlock", 1'b0, lg)
    fspsc_core_model_i.load(16'h0100, 16'hF100, lv, lg);
    `CHK("boot rlock", 1'b0, lg)
    @(posedge core_clk);
    chip_erase <= 1'b1;
    @(posedge core_clk);
    chip_erase <= 1'b0;
    reg_read(REG_LOCK, rd);
    `CHK("erase locks", 8'h0F, rd)
    fspsc_core_model_i.load(16'hF000, 16'h0100, lv, lg);
    `CHK("app open", 1'b1, lg)
    stop_test();
  end
endmodule

`default_nettype wire
